// ### hdl/pdc_counter.sv
// presettable four-bit up/down counter with separate up and down clocks
// assumes pins synchronous to clk_sys and an avalon-mm master on the bus

`timescale 1ns/1ps
`default_nettype none

module pdc_counter (
	input wire logic clk_sys,
	input wire logic rst,
	// counter pins
	input wire logic up_clock,
	input wire logic down_clock,
	input wire logic count_clear,
	input wire logic parallel_load_n,
	input wire logic [3:0] load_data,
	output logic [3:0] count_q,
	output logic overflow_n,
	output logic underflow_n,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ==========================================================
	// declarations
	logic up_q;
	logic up_rise;
	logic up_fall;
	logic down_q;
	logic down_rise;
	logic down_fall;
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic [3:0] count_inc;
	logic [3:0] count_dec;
	logic at_max;
	logic at_min;
	logic ovf_n_reg;
	logic unf_n_reg;
	logic bcd_reg;
	logic soft_clear_reg;
	logic soft_load_reg;
	logic [3:0] soft_ldata_reg;
	logic [15:0] event_cnt_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic clear_act;
	logic load_act;
	logic [3:0] load_val;
	logic step_up;
	logic step_down;
	logic bus_wr;
	logic bus_rd;

	// ==========================================================
	// count clock edges
	pdc_edge u_up_edge (
		.clk_sys(clk_sys),
		.rst(rst),
		.level_in(up_clock),
		.level_q(up_q),
		.rise(up_rise),
		.fall(up_fall)
	);

	pdc_edge u_down_edge (
		.clk_sys(clk_sys),
		.rst(rst),
		.level_in(down_clock),
		.level_q(down_q),
		.rise(down_rise),
		.fall(down_fall)
	);

	pdc_step u_step (
		.count(count_reg),
		.bcd(bcd_reg),
		.count_inc(count_inc),
		.count_dec(count_dec),
		.at_max(at_max),
		.at_min(at_min)
	);

	// ==========================================================
	// operation select
	// the other clock's level before this edge gates the step, so two
	// simultaneous rising edges give no count at all
	always_comb begin
		clear_act = count_clear | soft_clear_reg;
		load_act = ~parallel_load_n | soft_load_reg;
		// the pin load wins over a software load in the same cycle
		load_val = ~parallel_load_n ? load_data : soft_ldata_reg;
		step_up = up_rise & down_q & down_clock;
		step_down = down_rise & up_q & up_clock;
	end

	always_comb begin
		count_next = count_reg;
		if (clear_act) begin
			count_next = pdc_pkg::CNT_MIN;
		end else if (load_act) begin
			count_next = load_val;
		end else if (step_up) begin
			count_next = count_inc;
		end else if (step_down) begin
			count_next = count_dec;
		end
	end

	// ==========================================================
	// count state
	// clear and load act on the next clk_sys edge, independent of the
	// count clocks; this is the nearest a one-clock design gets
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_reg <= pdc_pkg::CNT_MIN;
		end else begin
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// terminal outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ovf_n_reg <= 1'b1;
		end else if (clear_act || load_act || up_rise || step_down) begin
			ovf_n_reg <= 1'b1;
		end else if (up_fall && down_q && at_max) begin
			ovf_n_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			unf_n_reg <= 1'b1;
		end else if (clear_act || load_act || down_rise || step_up) begin
			unf_n_reg <= 1'b1;
		end else if (down_fall && up_q && at_min) begin
			unf_n_reg <= 1'b0;
		end
	end

	// a chained stage sees these as its clocks, so they only fall
	// mid-cycle and rise with the next count edge, or sooner on a clear or load
	assign overflow_n = ovf_n_reg;
	assign underflow_n = unf_n_reg;
	assign count_q = count_reg;

	// ==========================================================
	// step counter, visible to software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			event_cnt_reg <= 16'h0000;
		end else if (bus_wr && avs_address == pdc_pkg::OFS_COUNT_EV) begin
			event_cnt_reg <= 16'h0000;
		end else if (!clear_act && !load_act && (step_up || step_down)) begin
			event_cnt_reg <= 16'(event_cnt_reg + 16'h0001);
		end
	end

	// ==========================================================
	// bus handshake
	// every access waits exactly one cycle; a write lands on the edge
	// where the master sees waitrequest low
	assign bus_wr = avs_write & ~wait_reg;
	assign bus_rd = avs_read & ~wait_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	// ==========================================================
	// control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bcd_reg <= pdc_pkg::CTRL_BCD_RST;
			soft_clear_reg <= 1'b0;
			soft_ldata_reg <= pdc_pkg::CTRL_LDATA_RST;
		end else if (bus_wr && avs_address == pdc_pkg::OFS_CTRL &&
				avs_byteenable[0]) begin
			bcd_reg <= avs_writedata[pdc_pkg::CTRL_BCD];
			soft_clear_reg <= avs_writedata[pdc_pkg::CTRL_SOFT_CLEAR];
			soft_ldata_reg <= avs_writedata[pdc_pkg::CTRL_LDATA_LO +: 4];
		end
	end

	// soft load is a one-cycle pulse, never held
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			soft_load_reg <= 1'b0;
		end else begin
			soft_load_reg <= bus_wr && avs_address == pdc_pkg::OFS_CTRL &&
				avs_byteenable[0] && avs_writedata[pdc_pkg::CTRL_SOFT_LOAD];
		end
	end

	// ==========================================================
	// read data
	always_comb begin
		rdata_next = 32'h00000000;
		case (avs_address)
			pdc_pkg::OFS_CTRL: begin
				rdata_next[pdc_pkg::CTRL_BCD] = bcd_reg;
				rdata_next[pdc_pkg::CTRL_SOFT_CLEAR] = soft_clear_reg;
				rdata_next[pdc_pkg::CTRL_LDATA_LO +: 4] = soft_ldata_reg;
			end
			pdc_pkg::OFS_STATUS: begin
				rdata_next[pdc_pkg::ST_COUNT_LO +: 4] = count_reg;
				rdata_next[pdc_pkg::ST_OVF_N] = ovf_n_reg;
				rdata_next[pdc_pkg::ST_UNF_N] = unf_n_reg;
				rdata_next[pdc_pkg::ST_UP_LVL] = up_q;
				rdata_next[pdc_pkg::ST_DOWN_LVL] = down_q;
				rdata_next[pdc_pkg::ST_BCD] = bcd_reg;
			end
			pdc_pkg::OFS_COUNT_EV: begin
				rdata_next[15:0] = event_cnt_reg;
			end
			default: begin
				rdata_next = 32'h00000000;
			end
		endcase
	end

	// data is loaded as waitrequest drops, so it stands at the edge
	// where the master samples it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_reg <= 32'h00000000;
		end else if (avs_read && wait_reg) begin
			rdata_reg <= rdata_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;

	// bus_rd marks the completing read cycle; kept for symmetry with writes
	logic unused_rd;
	assign unused_rd = bus_rd;

endmodule : pdc_counter

`default_nettype wire

// ### hdl/pdc_pkg.sv
// constants for the presettable dual-clock up/down counter
// assumes one system clock; all pins sampled on clk_sys

package pdc_pkg;

	// ==========================================================
	// counter widths and limits
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_MIN = 4'h0;
	localparam logic [3:0] CNT_MAX_BCD = 4'h9;
	localparam logic [3:0] CNT_MAX_BIN = 4'hf;

	// ==========================================================
	// register map, byte addresses on a 32-bit bus
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_COUNT_EV = 4'h8;

	// ctrl fields
	localparam int CTRL_BCD = 0;
	localparam int CTRL_SOFT_CLEAR = 1;
	localparam int CTRL_SOFT_LOAD = 2;
	localparam int CTRL_LDATA_LO = 4;
	localparam logic CTRL_BCD_RST = 1'h0;
	localparam logic [3:0] CTRL_LDATA_RST = 4'h0;

	// status fields
	localparam int ST_COUNT_LO = 0;
	localparam int ST_OVF_N = 4;
	localparam int ST_UNF_N = 5;
	localparam int ST_UP_LVL = 6;
	localparam int ST_DOWN_LVL = 7;
	localparam int ST_BCD = 8;

	// ==========================================================
	// terminal count of the selected variant
	function automatic logic [3:0] max_of(input logic bcd);
		max_of = bcd ? CNT_MAX_BCD : CNT_MAX_BIN;
	endfunction : max_of

endpackage : pdc_pkg

// ### hdl/pdc_edge.sv
// edge finder for one count clock pin
// assumes the pin is already synchronous to clk_sys and idles high

`timescale 1ns/1ps
`default_nettype none

module pdc_edge (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic level_in,
	output logic level_q,
	output logic rise,
	output logic fall
);

	// ==========================================================
	// previous level; resets high so an idle pin gives no edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			level_q <= 1'b1;
		end else begin
			level_q <= level_in;
		end
	end

	assign rise = level_in & ~level_q;
	assign fall = ~level_in & level_q;

endmodule : pdc_edge

`default_nettype wire

// ### hdl/pdc_step.sv
// next-count arithmetic for both variants
// assumes the caller decides whether a step happens at all

`timescale 1ns/1ps
`default_nettype none

module pdc_step (
	input wire logic [3:0] count,
	input wire logic bcd,
	output logic [3:0] count_inc,
	output logic [3:0] count_dec,
	output logic at_max,
	output logic at_min
);

	// ==========================================================
	// wrap arithmetic
	logic [3:0] top;

	always_comb begin
		top = pdc_pkg::max_of(bcd);
		at_max = (count == top);
		at_min = (count == pdc_pkg::CNT_MIN);
		// bcd codes above nine also step back to zero going up
		if (count >= top) begin
			count_inc = pdc_pkg::CNT_MIN;
		end else begin
			count_inc = 4'(count + 4'h1);
		end
		if (at_min) begin
			count_dec = top;
		end else begin
			count_dec = 4'(count - 4'h1);
		end
	end

endmodule : pdc_step

`default_nettype wire

// ### verif/pdc_counter_asserts.sv
// checker for the counter pins and the bus handshake
// assumes it is bound into pdc_counter and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pdc_counter_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic up_clock,
	input wire logic down_clock,
	input wire logic count_clear,
	input wire logic parallel_load_n,
	input wire logic [3:0] load_data,
	input wire logic [3:0] count_q,
	input wire logic overflow_n,
	input wire logic underflow_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	// ==========================================================
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic quiet;
	assign quiet = !count_clear && parallel_load_n;
	sequence s_up;
		$rose(up_clock) && down_clock && $past(down_clock) && quiet;
	endsequence
	sequence s_dn;
		$rose(down_clock) && up_clock && $past(up_clock) && quiet;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	AST_CLEAR: assert property (
		count_clear |=> count_q == 4'h0)
		else $error("count not cleared");
	AST_LOAD: assert property (
		!count_clear && !parallel_load_n |=> count_q == $past(load_data))
		else $error("count not preset");
	AST_UP: assert property (
		s_up |=> count_q == $past(count_q) + 4'h1 || count_q == 4'h0)
		else $error("bad up step");
	AST_DN: assert property (
		s_dn |=> count_q == $past(count_q) - 4'h1 ||
		count_q inside {4'h9, 4'hf})
		else $error("bad down step");
	AST_OVF: assert property (
		$fell(overflow_n) |-> $past(count_q) inside {4'h9, 4'hf} &&
		$past(up_clock, 2) && !$past(up_clock))
		else $error("overflow low out of turn");
	AST_UNF: assert property (
		$fell(underflow_n) |-> $past(count_q) == 4'h0 &&
		$past(down_clock, 2) && !$past(down_clock))
		else $error("underflow low out of turn");
	AST_UNF_SET: assert property (
		$fell(down_clock) && up_clock && $past(up_clock) &&
		count_q == 4'h0 && quiet |=> !underflow_n)
		else $error("underflow missed");
	AST_OVF_BACK: assert property (
		!overflow_n && $rose(up_clock) |=> overflow_n)
		else $error("overflow stuck low");
	AST_BUS: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
		else $error("bus answer late");
endmodule : pdc_counter_asserts
bind pdc_counter pdc_counter_asserts u_chk (.clk_sys, .rst, .up_clock,
	.down_clock, .count_clear, .parallel_load_n, .load_data, .count_q,
	.overflow_n, .underflow_n, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// ### verif/pdc_far_end.sv
// far-side logic driving the counter pins
// assumes tasks are called from the bench, one at a time
`timescale 1ns/1ps
`default_nettype none
module pdc_far_end (
	input wire logic clk_sys,
	output logic up_clock,
	output logic down_clock,
	output logic count_clear,
	output logic parallel_load_n,
	output logic [3:0] load_data
);
	// ==========================================================
	// pin drive; clocks idle high so no false edge is seen
	initial begin
		up_clock = 1'b1;
		down_clock = 1'b1;
		count_clear = 1'b0;
		parallel_load_n = 1'b1;
		load_data = 4'h0;
	end
	// the other clock is left high, so one direction counts; the pulse
	// falls and rises like a preceding stage's terminal output would
	task automatic press(input logic up);
		@(posedge clk_sys);
		if (up) begin
			up_clock <= 1'b0;
		end else begin
			down_clock <= 1'b0;
		end
	endtask : press
	task automatic lift();
		@(posedge clk_sys);
		up_clock <= 1'b1;
		down_clock <= 1'b1;
	endtask : lift
	// data inverted after use: no stale level left on the pins
	task automatic ctl(input logic clr, input logic ld, input logic [3:0] v);
		@(posedge clk_sys);
		count_clear <= clr;
		parallel_load_n <= !ld;
		load_data <= v;
		@(posedge clk_sys);
		count_clear <= 1'b0;
		parallel_load_n <= 1'b1;
		load_data <= ~v;
	endtask : ctl
endmodule : pdc_far_end
`default_nettype wire

// ### verif/pdc_counter_tb.sv
// self-checking bench for pdc_counter: pins, terminals, registers
// assumes pdc_far_end drives the pins and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module pdc_counter_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	wire logic up_clock, down_clock, count_clear, parallel_load_n;
	wire logic overflow_n, underflow_n, avs_waitrequest;
	wire logic [3:0] load_data, count_q;
	wire logic [31:0] avs_readdata;
	logic [31:0] rd;
	logic [3:0] cnt, mx;
	int mismatches = 0;
	int samples_checked = 0;
	int steps;
	always #50 clk_sys = ~clk_sys;
	pdc_far_end pm (.clk_sys, .up_clock, .down_clock, .count_clear,
		.parallel_load_n, .load_data);
	pdc_counter dut (.clk_sys, .rst, .up_clock, .down_clock, .count_clear,
		.parallel_load_n, .load_data, .count_q, .overflow_n, .underflow_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest);
	// ==========================================================
	// helpers
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk
	// bounded wait: a dead slave ends the run instead of hanging it
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			report_and_stop();
		end
	endtask : bus
	function automatic logic [3:0] nxt(input logic up, input logic [3:0] c);
		if (up) begin
			return (c >= mx) ? 4'h0 : c + 4'h1;
		end
		return (c == 4'h0) ? mx : c - 4'h1;
	endfunction : nxt
	task automatic step(input logic up, input int h);
		pm.press(up);
		repeat (h) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("overflow_n", !(up && cnt == mx), overflow_n);
		chk("underflow_n", !(!up && cnt == 4'h0), underflow_n);
		pm.lift();
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		cnt = nxt(up, cnt);
		steps++;
		chk("count_q", cnt, count_q);
		chk("overflow_n", 1'b1, overflow_n);
		chk("underflow_n", 1'b1, underflow_n);
	endtask : step
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(49));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk("count_q", 4'h0, count_q);
		bus(1'b0, pdc_pkg::OFS_STATUS, 32'h0);
		chk("status", 32'hf0, rd);
		bus(1'b1, 4'hc, 32'hff);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b0, pdc_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, rd);
		for (int b = 0; b < 2; b++) begin
			mx = b ? pdc_pkg::CNT_MAX_BCD : pdc_pkg::CNT_MAX_BIN;
			bus(1'b1, pdc_pkg::OFS_CTRL, 32'(b));
			bus(1'b1, pdc_pkg::OFS_COUNT_EV, 32'h0);
			steps = 0;
			pm.ctl(1'b1, 1'b1, 4'h5);
			@(negedge clk_sys);
			cnt = 4'h0;
			chk("count_q", cnt, count_q);
			for (int i = 0; i < 60; i++) begin
				if (i % 12 == 0) begin
					cnt = (i % 24 == 0) ? mx : 4'($urandom_range(3));
					pm.ctl(1'b0, 1'b1, cnt);
					@(negedge clk_sys);
					chk("count_q", cnt, count_q);
				end
				step(1'($urandom_range(1)), 1 + $urandom_range(2));
			end
			bus(1'b0, pdc_pkg::OFS_COUNT_EV, 32'h0);
			chk("steps", 32'(steps), rd);
			bus(1'b0, pdc_pkg::OFS_STATUS, 32'h0);
			chk("status", {23'h0, b[0], 4'hf, cnt}, rd);
			bus(1'b1, pdc_pkg::OFS_CTRL, 32'h34 | 32'(b));
			bus(1'b0, pdc_pkg::OFS_STATUS, 32'h0);
			chk("soft load", 4'h3, rd[3:0]);
			bus(1'b1, pdc_pkg::OFS_CTRL, 32'h2 | 32'(b));
			bus(1'b0, pdc_pkg::OFS_STATUS, 32'h0);
			chk("soft clear", 4'h0, rd[3:0]);
			bus(1'b1, pdc_pkg::OFS_CTRL, 32'(b));
			pm.press(1'b1);
			pm.press(1'b0);
			pm.lift();
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("count_q", 4'h0, count_q);
		end
		report_and_stop();
	end
endmodule : pdc_counter_tb
`default_nettype wire
